// >>> core/tba_consts.svh
`ifndef TBA_CONSTS_SVH
`define TBA_CONSTS_SVH

// Register byte offsets
`define TBA_OFF_CTRL 8'h00
`define TBA_OFF_STATUS 8'h04
`define TBA_OFF_TX_WORD 8'h08
`define TBA_OFF_CLKCOR 8'h0C
`define TBA_OFF_INT_STAT 8'h10
`define TBA_OFF_INT_MASK 8'h14

// Control field positions
`define TBA_CTRL_BOND_EN 0
`define TBA_CTRL_MINUS_EN 1
`define TBA_CTRL_PLUS_EN 2
`define TBA_CTRL_LB_LO 3
`define TBA_CTRL_LB_HI 4
`define TBA_CTRL_PWR_OFF 5
`define TBA_CTRL_MASTER 6

// Status field positions
`define TBA_ST_COMPLETE 0
`define TBA_ST_ALIGNED 1
`define TBA_ST_PWR_OFF 2
`define TBA_ST_BOND_LO 4
`define TBA_ST_BOND_HI 7
`define TBA_ST_WORD_LO 16
`define TBA_ST_WORD_HI 25

// Interrupt bit positions
`define TBA_INT_BOND 0
`define TBA_INT_REALIGN 1
`define TBA_INT_CLKCOR 2

// Reset values
`define TBA_RST_CTRL 7'h00
`define TBA_RST_TX_WORD 10'h0FA
`define TBA_RST_CLKCOR 10'h2AA
`define TBA_RST_INT_MASK 3'h0

// Line coding
`define TBA_WORD_LAST 4'h9
`define TBA_PLUS_COMMA 7'h1F
`define TBA_MINUS_COMMA 7'h60

`endif

// >>> core/tba_pkg.sv
`default_nettype none
package tba_pkg;

	// Link progress, Gray coded along off, hunt, aligned, bonded
	typedef enum logic [1:0] {
		LS_OFF = 2'b00,
		LS_HUNT = 2'b01,
		LS_ALIGN = 2'b11,
		LS_BOND = 2'b10
	} tba_link_e;

	// Bonding control bus between transceivers
	typedef struct packed {
		logic bond_mark;
		logic clkcor_mark;
		logic aligned;
		logic complete;
	} tba_bond_s;

	// Control register fields
	typedef struct packed {
		logic master;
		logic power_off;
		logic [1:0] loopback;
		logic plus_en;
		logic minus_en;
		logic bond_en;
	} tba_ctrl_s;

	// APB request from the master
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} tba_apb_req_s;

	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tba_apb_rsp_s;

	// Whole state of the top module
	typedef struct packed {
		tba_ctrl_s ctrl;
		logic [9:0] tx_word;
		logic [9:0] clkcor_word;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		tba_link_e link;
		logic [9:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [9:0] rx_word;
		logic [9:0] tx_sh;
		logic [3:0] tx_cnt;
		tba_bond_s bond_out;
		logic tx_pos;
		logic tx_neg;
		tba_apb_rsp_s rsp;
		logic irq;
		logic readback;
	} tba_state_s;

endpackage
`default_nettype wire

// >>> core/tba_sync2.sv
`default_nettype none
module tba_sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] safe;
	} tba_sync_s;

	tba_sync_s st_ff;
	tba_sync_s nxt_st;

	// First stage feeds only the second
	always_comb begin
		nxt_st.meta = din;
		nxt_st.safe = st_ff.meta;
	end

	// Two-stage register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_ff <= '0;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	assign dout = st_ff.safe;

endmodule
`default_nettype wire

// >>> core/tba_top.sv
// The address map and the APB interface to the registers were chosen for this implementation.
`include "tba_consts.svh"
`default_nettype none
module tba_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire tba_pkg::tba_apb_req_s apb_req,
	output tba_pkg::tba_apb_rsp_s apb_rsp,
	output logic irq,
	input wire logic serial_rx_pos,
	input wire logic serial_rx_neg,
	output logic serial_tx_pos,
	output logic serial_tx_neg,
	input wire tba_pkg::tba_bond_s bond_ctrl_in,
	output tba_pkg::tba_bond_s bond_ctrl_out,
	output logic bond_complete,
	input wire logic reconf_enable,
	input wire logic reconf_data_in,
	output logic readback_data_out
);
	import tba_pkg::*;

	tba_state_s st_ff;
	tba_state_s nxt_st;
	logic [1:0] rx_pins;
	tba_bond_s bond_in;
	logic rx_bit;
	logic rx_valid;
	logic [9:0] sh_new;
	logic [9:0] word;
	logic word_done;
	logic match;
	logic realign;
	logic comma_word;
	logic aligned;
	logic bond_hit;
	logic [2:0] ev;
	logic [2:0] clr;
	logic [31:0] rd;
	logic rd_err;
	logic wr_go;

	////////////////////////////////////////////////////////////////
	// Pin and peer synchronisers

	// Serial pads pass two flops
	tba_sync2 #(.W(2)) u_rx_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.clk_en(clk_en),
		.din({serial_rx_pos, serial_rx_neg}),
		.dout(rx_pins)
	);

	// Peer bonding bus comes from another clock
	tba_sync2 #(.W(4)) u_bond_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.clk_en(clk_en),
		.din(bond_ctrl_in),
		.dout(bond_in)
	);

	////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		nxt_st = st_ff;
		rx_bit = 1'b0;
		rx_valid = 1'b0;
		sh_new = st_ff.rx_sh;
		word = st_ff.rx_word;
		word_done = 1'b0;
		match = 1'b0;
		realign = 1'b0;
		comma_word = 1'b0;
		bond_hit = 1'b0;
		ev = 3'h0;
		clr = 3'h0;
		rd = 32'h0000_0000;
		rd_err = 1'b0;
		wr_go = 1'b0;
		aligned = (st_ff.link == LS_ALIGN) || (st_ff.link == LS_BOND);
		nxt_st.bond_out.bond_mark = 1'b0;
		nxt_st.bond_out.clkcor_mark = 1'b0;
		nxt_st.readback = 1'b0;

		// Transmit serializer, sends msb first
		if (st_ff.ctrl.power_off) begin
			nxt_st.tx_sh = 10'h000;
			nxt_st.tx_cnt = 4'h0;
			nxt_st.tx_pos = 1'b0;
			nxt_st.tx_neg = 1'b0;
		end else begin
			if (st_ff.tx_cnt == `TBA_WORD_LAST) begin
				nxt_st.tx_cnt = 4'h0;
				nxt_st.tx_sh = st_ff.tx_word;
			end else begin
				nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;
				nxt_st.tx_sh = {st_ff.tx_sh[8:0], 1'b0};
			end
			nxt_st.tx_pos = st_ff.tx_sh[9];
			nxt_st.tx_neg = ~st_ff.tx_sh[9];
		end

		// Receive path and comma alignment
		if (st_ff.ctrl.power_off) begin
			nxt_st.rx_sh = 10'h000;
			nxt_st.rx_cnt = 4'h0;
		end else if (st_ff.ctrl.loopback[0]) begin
			// Parallel loopback takes the transmit word
			word_done = (st_ff.tx_cnt == `TBA_WORD_LAST);
			word = st_ff.tx_word;
			match = (st_ff.ctrl.plus_en && word[9:3] == `TBA_PLUS_COMMA) ||
				(st_ff.ctrl.minus_en && word[9:3] == `TBA_MINUS_COMMA);
		end else begin
			if (st_ff.ctrl.loopback[1]) begin
				rx_bit = st_ff.tx_pos;
				rx_valid = 1'b1;
			end else begin
				rx_bit = rx_pins[1];
				rx_valid = rx_pins[1] ^ rx_pins[0]; // Equal legs carry no bit
			end
			if (rx_valid) begin
				sh_new = {st_ff.rx_sh[8:0], rx_bit};
				match = (st_ff.ctrl.plus_en && sh_new[9:3] == `TBA_PLUS_COMMA) ||
					(st_ff.ctrl.minus_en && sh_new[9:3] == `TBA_MINUS_COMMA);
				realign = match && (st_ff.rx_cnt != `TBA_WORD_LAST);
				word_done = (st_ff.rx_cnt == `TBA_WORD_LAST) || realign;
				word = sh_new;
				nxt_st.rx_sh = sh_new;
				nxt_st.rx_cnt = word_done ? 4'h0 : st_ff.rx_cnt + 4'h1;
			end
		end
		if (word_done) begin
			nxt_st.rx_word = word;
		end
		comma_word = word_done && match;

		// Clock correction seen locally or from the master
		if (word_done && word == st_ff.clkcor_word) begin
			ev[`TBA_INT_CLKCOR] = 1'b1;
			nxt_st.bond_out.clkcor_mark = st_ff.ctrl.master;
		end
		if (!st_ff.ctrl.master && st_ff.ctrl.bond_en && bond_in.clkcor_mark) begin
			ev[`TBA_INT_CLKCOR] = 1'b1;
		end
		if (realign && aligned) begin
			ev[`TBA_INT_REALIGN] = 1'b1;
		end

		// Master marks bonding on boundary commas, slave follows
		if (st_ff.ctrl.master) begin
			bond_hit = st_ff.ctrl.bond_en && comma_word;
			nxt_st.bond_out.bond_mark = bond_hit && aligned;
		end else begin
			bond_hit = st_ff.ctrl.bond_en && bond_in.bond_mark;
		end

		// Link state machine
		case (st_ff.link)
			LS_OFF: begin
				nxt_st.link = LS_HUNT;
			end
			LS_HUNT: begin
				if (comma_word) begin
					nxt_st.link = LS_ALIGN;
				end
			end
			LS_ALIGN: begin
				if (bond_hit && !realign) begin
					nxt_st.link = LS_BOND;
					ev[`TBA_INT_BOND] = 1'b1;
				end
			end
			LS_BOND: begin
				if (!st_ff.ctrl.bond_en || realign) begin
					nxt_st.link = LS_ALIGN;
				end
			end
			default: begin
				nxt_st.link = LS_OFF;
			end
		endcase
		if (st_ff.ctrl.power_off) begin
			nxt_st.link = LS_OFF;
			nxt_st.bond_out.bond_mark = 1'b0;
			nxt_st.bond_out.clkcor_mark = 1'b0;
			ev = 3'h0;
		end
		nxt_st.bond_out.aligned = (nxt_st.link == LS_ALIGN) || (nxt_st.link == LS_BOND);
		nxt_st.bond_out.complete = (nxt_st.link == LS_BOND);

		// Read data decode at setup phase
		if (apb_req.paddr == `TBA_OFF_CTRL) begin
			rd[`TBA_CTRL_BOND_EN] = st_ff.ctrl.bond_en;
			rd[`TBA_CTRL_MINUS_EN] = st_ff.ctrl.minus_en;
			rd[`TBA_CTRL_PLUS_EN] = st_ff.ctrl.plus_en;
			rd[`TBA_CTRL_LB_HI:`TBA_CTRL_LB_LO] = st_ff.ctrl.loopback;
			rd[`TBA_CTRL_PWR_OFF] = st_ff.ctrl.power_off;
			rd[`TBA_CTRL_MASTER] = st_ff.ctrl.master;
		end else if (apb_req.paddr == `TBA_OFF_STATUS) begin
			rd[`TBA_ST_COMPLETE] = st_ff.bond_out.complete;
			rd[`TBA_ST_ALIGNED] = st_ff.bond_out.aligned;
			rd[`TBA_ST_PWR_OFF] = (st_ff.link == LS_OFF);
			rd[`TBA_ST_BOND_HI:`TBA_ST_BOND_LO] = bond_in;
			rd[`TBA_ST_WORD_HI:`TBA_ST_WORD_LO] = st_ff.rx_word;
		end else if (apb_req.paddr == `TBA_OFF_TX_WORD) begin
			rd[9:0] = st_ff.tx_word;
		end else if (apb_req.paddr == `TBA_OFF_CLKCOR) begin
			rd[9:0] = st_ff.clkcor_word;
		end else if (apb_req.paddr == `TBA_OFF_INT_STAT) begin
			rd[2:0] = st_ff.int_stat;
		end else if (apb_req.paddr == `TBA_OFF_INT_MASK) begin
			rd[2:0] = st_ff.int_mask;
		end else begin
			rd_err = 1'b1; // Unmapped address
		end

		// Answer is registered, ready in the access phase
		nxt_st.rsp.pready = apb_req.psel && !apb_req.penable;
		if (apb_req.psel && !apb_req.penable) begin
			nxt_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
			nxt_st.rsp.pslverr = rd_err;
		end
		wr_go = apb_req.psel && apb_req.penable && st_ff.rsp.pready &&
			apb_req.pwrite && !st_ff.rsp.pslverr;

		// Register writes at the access edge
		if (wr_go) begin
			if (apb_req.paddr == `TBA_OFF_CTRL) begin
				nxt_st.ctrl.bond_en = apb_req.pwdata[`TBA_CTRL_BOND_EN];
				nxt_st.ctrl.minus_en = apb_req.pwdata[`TBA_CTRL_MINUS_EN];
				nxt_st.ctrl.plus_en = apb_req.pwdata[`TBA_CTRL_PLUS_EN];
				nxt_st.ctrl.loopback = apb_req.pwdata[`TBA_CTRL_LB_HI:`TBA_CTRL_LB_LO];
				nxt_st.ctrl.power_off = apb_req.pwdata[`TBA_CTRL_PWR_OFF];
				nxt_st.ctrl.master = apb_req.pwdata[`TBA_CTRL_MASTER];
			end else if (apb_req.paddr == `TBA_OFF_TX_WORD) begin
				nxt_st.tx_word = apb_req.pwdata[9:0];
			end else if (apb_req.paddr == `TBA_OFF_CLKCOR) begin
				nxt_st.clkcor_word = apb_req.pwdata[9:0];
			end else if (apb_req.paddr == `TBA_OFF_INT_STAT) begin
				clr = apb_req.pwdata[2:0];
			end else if (apb_req.paddr == `TBA_OFF_INT_MASK) begin
				nxt_st.int_mask = apb_req.pwdata[2:0];
			end
		end

		// Sticky events, a new event beats a clear
		nxt_st.int_stat = (st_ff.int_stat & ~clr) | ev;
		nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);
	end

	////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.ctrl <= `TBA_RST_CTRL;
			st_ff.tx_word <= `TBA_RST_TX_WORD;
			st_ff.clkcor_word <= `TBA_RST_CLKCOR;
			st_ff.int_mask <= `TBA_RST_INT_MASK;
			st_ff.link <= LS_OFF;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs straight from the state register

	assign apb_rsp = st_ff.rsp;
	assign irq = st_ff.irq;
	assign serial_tx_pos = st_ff.tx_pos;
	assign serial_tx_neg = st_ff.tx_neg;
	assign bond_ctrl_out = st_ff.bond_out;
	assign bond_complete = st_ff.bond_out.complete;
	assign readback_data_out = st_ff.readback;

endmodule
`default_nettype wire

// >>> verification/tba_top_monitor.sv
`default_nettype none
module tba_mon import tba_pkg::*; (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire tba_pkg::tba_apb_req_s apb_req,
	input wire tba_pkg::tba_apb_rsp_s apb_rsp,
	input wire logic serial_tx_pos,
	input wire logic serial_tx_neg,
	input wire tba_pkg::tba_bond_s bond_ctrl_out,
	input wire logic bond_complete,
	input wire logic readback_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic bad_addr;
	////////////////////////////////////////
	// Words past the last register, or offsets that are not word aligned
	assign bad_addr = (apb_req.paddr[7:2] > 6'h05) || (apb_req.paddr[1:0] != 2'h0);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	// Setup cycle of a transfer
	sequence s_setup;
		clk_en && apb_req.psel && !apb_req.penable;
	endsequence
	// Setup aimed at an unmapped word
	sequence s_bad_setup;
		s_setup ##0 bad_addr;
	endsequence
	////////////////////////////////////////
	// Outputs quiet after reset
	AST_RST_QUIET: assert property (disable iff (1'b0) srst && clk_en |=>
		!bond_complete && bond_ctrl_out == 4'h0 && !apb_rsp.pready && !serial_tx_pos)
		else $error("outputs active after reset");
	AST_APB_READY: assert property (s_setup |=> apb_rsp.pready)
		else $error("no ready after setup");
	AST_READY_CAUSE: assert property (apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable))
		else $error("ready without setup");
	AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready longer than one cycle");
	AST_UNMAPPED_ERR: assert property (s_bad_setup |=> apb_rsp.pslverr)
		else $error("unmapped access not refused");
	AST_MAPPED_OK: assert property (s_setup ##0 !bad_addr |=> !apb_rsp.pslverr)
		else $error("mapped access refused");
	AST_BOND_MARK_PULSE: assert property (bond_ctrl_out.bond_mark |=> !bond_ctrl_out.bond_mark)
		else $error("bond mark longer than one cycle");
	AST_TX_LEGS: assert property (serial_tx_pos |-> !serial_tx_neg)
		else $error("both transmit legs high");
	AST_OFF_NOT_BONDED: assert property ((!serial_tx_pos && !serial_tx_neg) [*2] |->
		!bond_complete)
		else $error("bonded while transmitter off");
	AST_READBACK_ZERO: assert property (!readback_data_out)
		else $error("readback output active");
endmodule
bind tba_top tba_mon mon (.sys_clk, .srst, .clk_en, .apb_req, .apb_rsp, .serial_tx_pos,
	.serial_tx_neg, .bond_ctrl_out, .bond_complete, .readback_data_out);
`default_nettype wire

// >>> verification/tba_peer.sv
`default_nettype none
module tba_peer import tba_pkg::*; (
	input wire logic sys_clk,
	input wire logic send,
	input wire logic [9:0] word,
	input wire logic mark,
	output logic rx_pos,
	output logic rx_neg,
	output tba_pkg::tba_bond_s bond
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] idx;
	logic idle_bit;
	////////////////////////////////////////
	// Start quiet
	initial begin
		idx = 4'h0;
		idle_bit = 1'b0;
		rx_pos = 1'b0;
		rx_neg = 1'b0;
		bond = '0;
	end
	// Serial word out msb first; equal toggling legs carry no bit
	always @(posedge sys_clk) begin
		idle_bit <= ~idle_bit;
		rx_pos <= send ? word[4'h9 - idx] : idle_bit;
		rx_neg <= send ? ~word[4'h9 - idx] : idle_bit;
		idx <= (!send || idx == 4'h9) ? 4'h0 : idx + 4'h1;
	end
	// Bonding control as a peer master drives it
	always @(posedge sys_clk) begin
		bond.bond_mark <= mark;
		bond.clkcor_mark <= 1'b0;
		bond.aligned <= send;
		bond.complete <= 1'b0;
	end
endmodule
`default_nettype wire

// >>> verification/tb_transceiver_bonding_align_control.sv
`include "tba_consts.svh"
`default_nettype none
module tb_transceiver_bonding_align_control import tba_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] RA [5] = '{`TBA_OFF_CTRL, `TBA_OFF_TX_WORD, `TBA_OFF_CLKCOR,
		`TBA_OFF_INT_STAT, `TBA_OFF_INT_MASK};
	localparam logic [31:0] RV [5] = '{32'h0, 32'h0FA, 32'h2AA, 32'h0, 32'h0};
	localparam logic [31:0] RW [5] = '{32'h7F, 32'h3FF, 32'h3FF, 32'h7, 32'h7};
	localparam logic [6:0] TC [5] = '{7'h57, 7'h55, 7'h53, 7'h55, 7'h56};
	localparam logic [9:0] TW [5] = '{10'h0FA, 10'h0FA, 10'h305, 10'h305, 10'h0FA};
	logic sys_clk, srst, clk_en, irq, serial_tx_pos, serial_tx_neg, bond_complete;
	logic serial_rx_pos, serial_rx_neg, rcf_en, rcf_din, peer_send, peer_mark, er;
	logic [9:0] peer_word;
	logic [31:0] rd, wd;
	tba_apb_req_s req;
	tba_apb_rsp_s rsp;
	tba_bond_s bond_in, bond_out;
	int bad_count, samples_checked, seed, mark_cnt;
	////////////////////////////////////////
	tba_top dut (.sys_clk, .srst, .clk_en, .apb_req(req), .apb_rsp(rsp), .irq, .serial_rx_pos,
		.serial_rx_neg, .serial_tx_pos, .serial_tx_neg, .bond_ctrl_in(bond_in),
		.bond_ctrl_out(bond_out), .bond_complete, .reconf_enable(rcf_en),
		.reconf_data_in(rcf_din), .readback_data_out());
	tba_peer peer (.sys_clk, .send(peer_send), .word(peer_word), .mark(peer_mark),
		.rx_pos(serial_rx_pos), .rx_neg(serial_rx_neg), .bond(bond_in));
	// Clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#1500000;
		stall();
	end
	// Unused reconfiguration inputs wiggle; bond marks counted
	always @(posedge sys_clk) begin
		rcf_en <= ~rcf_en;
		rcf_din <= rcf_en ^ rcf_din;
		mark_cnt <= mark_cnt + int'(bond_out.bond_mark === 1'b1);
	end
	////////////////////////////////////////
	function automatic logic exp_bond(input logic [6:0] c, input logic [9:0] w);
		return c[0] && ((c[2] && w[9:3] == 7'h1F) || (c[1] && w[9:3] == 7'h60));
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic stall();
		bad_count++;
		$display("BAD %0t wait ran out", $time);
		finish_test();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 40);
		if (n >= 40) stall();
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wait_bond(input logic exp);
		int n;
		n = 0;
		while (bond_complete !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (2) @(posedge sys_clk);
		chk1(bond_complete, exp, "bond complete");
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		int m;
		req = '0;
		{srst, clk_en, rcf_en, rcf_din, peer_send, peer_mark} = 6'h30;
		{peer_word, seed, bad_count, samples_checked, mark_cnt} = {10'h0, 32'h8CFB7E91, 96'h0};
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, RA[k], 32'h0);
			chk(rd, RV[k], "reset value");
		end
		for (int j = 0; j < 8; j++) begin
			m = (j % 4 == 3) ? 4 : j % 4;
			wd = $random(seed);
			apb(1'b1, RA[m], wd);
			apb(1'b0, RA[m], 32'h0);
			chk(rd, wd & RW[m], "readback");
		end
		// Random mask and stale events from above must not leak into irq checks
		apb(1'b1, `TBA_OFF_INT_MASK, 32'h0);
		apb(1'b1, `TBA_OFF_INT_STAT, 32'h7);
		apb(1'b1, 8'h18, 32'hFFFFFFFF);
		chk1(er, 1'b1, "unmapped write");
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er} ^ rd, 32'h1, "unmapped read");
		// Serial loopback: enables, comma polarity, power off
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `TBA_OFF_TX_WORD, {22'h0, TW[i]});
			apb(1'b1, `TBA_OFF_CTRL, {25'h0, TC[i] | 7'h20});
			repeat (20) @(posedge sys_clk);
			chk({29'h0, bond_complete, serial_tx_pos, serial_tx_neg}, 32'h0, "off");
			apb(1'b0, `TBA_OFF_STATUS, 32'h0);
			chk(rd & 32'h7, 32'h4, "off status");
			m = mark_cnt;
			apb(1'b1, `TBA_OFF_CTRL, {25'h0, TC[i]});
			wait_bond(exp_bond(TC[i], TW[i]));
			chk1(mark_cnt != m, exp_bond(TC[i], TW[i]), "mark out");
			chk1(bond_out.complete, exp_bond(TC[i], TW[i]), "complete out");
			if (i == 0) begin
				apb(1'b0, `TBA_OFF_INT_STAT, 32'h0);
				chk1(rd[0] | irq, 1'b1, "bond event unmasked");
				chk1(irq, 1'b0, "masked irq");
				apb(1'b1, `TBA_OFF_INT_MASK, 32'h1);
				repeat (2) @(posedge sys_clk);
				chk1(irq, 1'b1, "irq raised");
				apb(1'b1, `TBA_OFF_INT_STAT, 32'h1);
				repeat (2) @(posedge sys_clk);
				chk1(irq, 1'b0, "irq cleared");
			end
		end
		// Parallel loopback, also winning over serial
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `TBA_OFF_TX_WORD, $random(seed));
			m = req.pwdata[9:0];
			apb(1'b1, `TBA_OFF_CTRL, (i % 2) ? 32'h18 : 32'h08);
			repeat (40) @(posedge sys_clk);
			apb(1'b0, `TBA_OFF_STATUS, 32'h0);
			chk(rd & 32'h03FF0000, {6'h0, m[9:0], 16'h0}, "parallel word");
		end
		// Slave bonds on the peer's mark only
		peer_word <= 10'h0FA;
		peer_send <= 1'b1;
		apb(1'b1, `TBA_OFF_CTRL, 32'h07);
		repeat (100) @(posedge sys_clk);
		apb(1'b0, `TBA_OFF_STATUS, 32'h0);
		chk(rd & 32'hFF, 32'h22, "slave aligned");
		peer_mark <= 1'b1;
		@(posedge sys_clk);
		peer_mark <= 1'b0;
		wait_bond(1'b1);
		apb(1'b1, `TBA_OFF_CTRL, 32'h06);
		repeat (4) @(posedge sys_clk);
		chk1(bond_complete, 1'b0, "bond dropped");
		peer_send <= 1'b0;
		finish_test();
	end
endmodule
`default_nettype wire
